//--- core/sfr_core.sv
/*
 Core special-function register block: indirect ports and pointers,
 extended direct addressing, accumulator, program-counter low byte,
 table read pointers and status.
 Assumes the instruction sequencer issues one access per cycle and holds
 off while busy is high; program memory answers a fetch in the same cycle.
 The special area exists in sector 0 only; general memory and status
 are kept in their own submodules.
*/
`timescale 1ns/100ps

// Function
// - Direct port access reads zero, ignores writes
// - Port zero uses pointer zero, sector zero
// - Ports one, two: low address, high sector
// - All five pointer bytes are real storage
// - Unused special locations read zero
// - Extended address: upper sector, low location
// - Program-counter low write jumps within page
// - That write adds one dummy cycle
// - Table read latches high byte
// - Table read low byte goes to destination at 80h or above
// - Table pointers are ordinary writable registers
// - Status is eight bits of flags
// - Status writes spare power-down and time-out
// - Time-out changes only on its events
// - Power-down changes only on its events
// - Arithmetic flags track latest result
// - Accumulator holds ALU results, transfers pass it
// - Status bit layout; protected bits reset zero
// - Halt sets power-down, clear or power-up clears
module sfr_core
   import sfr_pkg::*;
#(
   parameter int PC_W    = 13,
   parameter int SECTORS = 2
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            sys_rst,

   // Data access
   input  wire sfr_acc_t        acc_req,
   output logic [7:0]           rdata_q,

   // ALU results
   input  wire logic            acc_load,
   input  wire logic [7:0]      alu_result,
   input  wire sfr_flag_t       alu_flags,

   // Program counter
   input  wire logic            pc_step,
   input  wire logic            pc_load,
   input  wire logic [PC_W-1:0] pc_target,
   output logic [PC_W-1:0]      pc_q,

   // Table read
   input  wire logic            table_read,
   input  wire logic [7:0]      table_dest,
   output logic [PC_W-1:0]      prog_addr,
   input  wire logic [15:0]     prog_word,

   // System events
   input  wire logic            halt_instr,
   input  wire logic            watchdog_clear_instr,
   input  wire logic            dog_expired,

   // Sequencer and visible registers
   output logic                 busy,
   output logic [7:0]           accumulator_q,
   output logic [7:0]           status_flags
);
   // Sequencer state
   sfr_state_t  state_q;
   sfr_state_t  state_d;
   // Memory pointers
   logic [7:0]  pointer_zero_q;
   logic [7:0]  pointer_one_low_q;
   logic [7:0]  pointer_one_sector_q;
   logic [7:0]  pointer_two_low_q;
   logic [7:0]  pointer_two_sector_q;
   // Table read path
   logic [7:0]  table_pointer_low_q;
   logic [7:0]  table_pointer_high_q;
   logic [7:0]  table_data_high_q;
   logic [7:0]  table_dest_q;
   logic [7:0]  table_low_q;
   // Read data next value
   logic [7:0]  rdata_d;

   // Is a special-function offset one of the indirect ports
   function automatic logic is_port(input logic [7:0] a);
      return (a == SFR_IND0) || (a == SFR_IND1) || (a == SFR_IND2);
   endfunction

   // Location reached through port a, given the pointers
   // Pointer zero has no sector byte, so it never leaves sector 0
   function automatic sfr_loc_t port_loc(input logic [7:0] a,
                                         input logic [7:0] p0,
                                         input logic [7:0] p1l,
                                         input logic [7:0] p1s,
                                         input logic [7:0] p2l,
                                         input logic [7:0] p2s);
      sfr_loc_t l;
      l = '{sector: 8'h00, addr: p0};
      if (a == SFR_IND1) begin
         l = '{sector: p1s, addr: p1l};
      end
      if (a == SFR_IND2) begin
         l = '{sector: p2s, addr: p2l};
      end
      return l;
   endfunction

   // Address resolution: direct, extended or through a port
   wire        run       = state_q == SFR_RUN;
   wire        req_rd    = run && acc_req.rd;
   wire        req_wr    = run && acc_req.wr;
   // Extended accesses bring their own sector; plain ones use sector 0
   wire [7:0]  dir_sec   = acc_req.ext ? acc_req.sector : 8'h00;
   // Only a plain access to a port offset goes through a pointer
   wire        via_port  = !acc_req.ext && is_port(acc_req.addr);
   sfr_loc_t   ind_loc;
   assign ind_loc = port_loc(acc_req.addr, pointer_zero_q, pointer_one_low_q,
                             pointer_one_sector_q, pointer_two_low_q,
                             pointer_two_sector_q);
   sfr_loc_t   eff_loc;
   assign eff_loc = via_port ? ind_loc : sfr_loc_t'{sector: dir_sec, addr: acc_req.addr};

   // An indirect access that lands on a port again is treated as unused
   // so that a pointer aimed at a port never chains a second lookup
   wire        ind_on_port = via_port && ind_loc.sector == 8'h00
                             && is_port(ind_loc.addr);
   wire        sfr_space   = eff_loc.sector == 8'h00
                             && eff_loc.addr < SFR_GP_BASE && !ind_on_port;
   wire [7:0]  sfr_a       = eff_loc.addr;
   wire        sfr_wr      = req_wr && sfr_space;

   // Per-register write strobes
   wire wr_p0   = sfr_wr && sfr_a == SFR_PTR0;
   wire wr_p1l  = sfr_wr && sfr_a == SFR_PTR1L;
   wire wr_p1s  = sfr_wr && sfr_a == SFR_PTR1S;
   wire wr_p2l  = sfr_wr && sfr_a == SFR_PTR2L;
   wire wr_p2s  = sfr_wr && sfr_a == SFR_PTR2S;

   // Accumulator, counter, table and status strobes
   wire wr_acc  = sfr_wr && sfr_a == SFR_ACC;
   wire wr_pcl  = sfr_wr && sfr_a == SFR_PCLO;
   wire wr_tbpl = sfr_wr && sfr_a == SFR_TBPL;
   wire wr_tbph = sfr_wr && sfr_a == SFR_TBPH;
   wire wr_stat = sfr_wr && sfr_a == SFR_STAT;
   // Table fetch; a jump in the same cycle takes precedence
   wire tbl_take = run && table_read && !wr_pcl;

   // General-purpose memory: table result or instruction data
   wire        tbl_wb   = state_q == SFR_TBL;
   sfr_loc_t   ram_loc;
   assign ram_loc = tbl_wb ? sfr_loc_t'{sector: 8'h00, addr: table_dest_q} : eff_loc;
   // A table result aimed below 80h is dropped, not written into the map
   wire        tbl_to_gp = table_dest_q >= SFR_GP_BASE;
   wire        ram_we   = (tbl_wb && tbl_to_gp)
                          || (req_wr && !sfr_space && !ind_on_port);
   wire [7:0]  ram_wd   = tbl_wb ? table_low_q : acc_req.wdata;
   wire [7:0]  ram_rd;
   wire        ram_hit;

   sfr_ram #(
      .SECTORS (SECTORS)
   ) u_ram (
      .clock   (clock),
      .sys_rst (sys_rst),
      .we      (ram_we),
      .loc     (ram_loc),
      .wdata   (ram_wd),
      .rdata   (ram_rd),
      .hit     (ram_hit)
   );

   // ALU updates outrank an instruction write of the status
   sfr_status u_status (
      .clock                (clock),
      .sys_rst              (sys_rst),
      .wr                   (wr_stat),
      .wdata                (acc_req.wdata),
      .flg                  (alu_flags),
      .halt_instr           (halt_instr),
      .watchdog_clear_instr (watchdog_clear_instr),
      .dog_expired          (dog_expired),
      .status_q             (status_flags)
   );

   // Special-function read multiplexer
   // Ports and unused offsets fall through to zero
   logic [7:0] sfr_rd;
   always_comb begin
      case (sfr_a)
         SFR_PTR0:  sfr_rd = pointer_zero_q;
         SFR_PTR1L: sfr_rd = pointer_one_low_q;
         SFR_PTR1S: sfr_rd = pointer_one_sector_q;
         SFR_PTR2L: sfr_rd = pointer_two_low_q;
         SFR_PTR2S: sfr_rd = pointer_two_sector_q;
         SFR_ACC:   sfr_rd = accumulator_q;
         SFR_PCLO:  sfr_rd = pc_q[7:0];
         SFR_TBPL:  sfr_rd = table_pointer_low_q;
         SFR_TBDH:  sfr_rd = table_data_high_q;
         SFR_TBPH:  sfr_rd = table_pointer_high_q;
         SFR_STAT:  sfr_rd = status_flags;
         default:   sfr_rd = READ_NONE;
      endcase
   end

   // Read data: ports and missing locations give zero
   // The byte is held between reads, so a late sample still sees it
   always_comb begin
      rdata_d = rdata_q;
      if (req_rd) begin
         if (ind_on_port) begin
            rdata_d = READ_NONE;
         end else if (sfr_space) begin
            rdata_d = sfr_rd;
         end else if (ram_hit) begin
            rdata_d = ram_rd;
         end else begin
            rdata_d = READ_NONE;
         end
      end
   end

   // Sequencer: dummy after a jump, one cycle to store table low byte
   // The dummy cycle gives the fetch at the new address time to settle
   always_comb begin
      case (state_q)
         SFR_RUN: begin
            if (wr_pcl) begin
               state_d = SFR_DUMMY;
            end else if (tbl_take) begin
               state_d = SFR_TBL;
            end else begin
               state_d = SFR_RUN;
            end
         end
         SFR_DUMMY: begin
            state_d = SFR_RUN;
         end
         SFR_TBL: begin
            state_d = SFR_RUN;
         end
         default: state_d = SFR_RUN;
      endcase
   end
   assign busy      = state_q != SFR_RUN;
   assign prog_addr = PC_W'({table_pointer_high_q, table_pointer_low_q});

   // Accumulator: ALU results and explicit writes only
   // An ALU load outranks an instruction write in the same cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         accumulator_q <= RST_BYTE;
      end else if (acc_load) begin
         accumulator_q <= alu_result;
      end else if (wr_acc) begin
         accumulator_q <= acc_req.wdata;
      end
   end

   // Program counter: low-byte write keeps the page bits
   // Only eight bits are written, so the target stays in this page
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_q <= '0;
      end else if (wr_pcl) begin
         pc_q <= {pc_q[PC_W-1:8], acc_req.wdata};
      end else if (pc_load) begin
         pc_q <= pc_target;
      end else if (pc_step && run) begin
         pc_q <= pc_q + PC_W'(1);
      end
   end

   // Memory pointers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pointer_zero_q       <= RST_BYTE;
         pointer_one_low_q    <= RST_BYTE;
         pointer_one_sector_q <= RST_BYTE;
         pointer_two_low_q    <= RST_BYTE;
         pointer_two_sector_q <= RST_BYTE;
      end else begin
         if (wr_p0) begin
            pointer_zero_q <= acc_req.wdata;
         end
         if (wr_p1l) begin
            pointer_one_low_q <= acc_req.wdata;
         end
         if (wr_p1s) begin
            pointer_one_sector_q <= acc_req.wdata;
         end
         if (wr_p2l) begin
            pointer_two_low_q <= acc_req.wdata;
         end
         if (wr_p2s) begin
            pointer_two_sector_q <= acc_req.wdata;
         end
      end
   end

   // Table pointers and fetched word
   // Both bytes are taken in the fetch cycle; the low byte waits one
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         table_pointer_low_q  <= RST_BYTE;
         table_pointer_high_q <= RST_BYTE;
         table_data_high_q    <= RST_BYTE;
         table_dest_q         <= RST_BYTE;
         table_low_q          <= RST_BYTE;
      end else begin
         if (wr_tbpl) begin
            table_pointer_low_q <= acc_req.wdata;
         end
         if (wr_tbph) begin
            table_pointer_high_q <= acc_req.wdata;
         end
         if (tbl_take) begin
            table_data_high_q <= prog_word[15:8];
            table_low_q       <= prog_word[7:0];
            table_dest_q      <= table_dest;
         end
      end
   end

   // State and read data registers
   // Reset returns the sequencer to normal running
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= SFR_RUN;
         rdata_q <= RST_BYTE;
      end else begin
         state_q <= state_d;
         rdata_q <= rdata_d;
      end
   end
endmodule

//--- core/sfr_pkg.sv
/*
 Package for the core special-function register block: offsets, status
 bit positions, reset values, port carriers and the access state machine.
 Assumes an 8-bit data path and a 16-bit program-memory word.
*/
package sfr_pkg;
   // Special-function offsets in sector 0
   localparam logic [7:0] SFR_IND0   = 8'h00;
   localparam logic [7:0] SFR_PTR0   = 8'h01;
   localparam logic [7:0] SFR_IND1   = 8'h02;
   localparam logic [7:0] SFR_PTR1L  = 8'h03;
   localparam logic [7:0] SFR_PTR1S  = 8'h04;
   localparam logic [7:0] SFR_ACC    = 8'h05;
   localparam logic [7:0] SFR_PCLO   = 8'h06;
   localparam logic [7:0] SFR_TBPL   = 8'h07;
   localparam logic [7:0] SFR_TBDH   = 8'h08;
   localparam logic [7:0] SFR_TBPH   = 8'h09;
   localparam logic [7:0] SFR_STAT   = 8'h0A;
   localparam logic [7:0] SFR_IND2   = 8'h0C;
   localparam logic [7:0] SFR_PTR2L  = 8'h0D;
   localparam logic [7:0] SFR_PTR2S  = 8'h0E;
   // First general-purpose location of a sector
   localparam logic [7:0] SFR_GP_BASE = 8'h80;
   // Status bit positions
   localparam int ST_C  = 0;
   localparam int ST_AC = 1;
   localparam int ST_Z  = 2;
   localparam int ST_OV = 3;
   localparam int ST_PD = 4;
   localparam int ST_TO = 5;
   localparam int ST_CZ = 6;
   localparam int ST_SC = 7;
   // Bits that an instruction write may change
   localparam logic [7:0] ST_WR_MASK = 8'hCF;
   // Reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] READ_NONE  = 8'h00;
   // Dummy cycles after a program-counter low write
   localparam int PCL_DUMMY_CYC = 1;

   // Data access from the instruction sequencer
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       ext;      // Extended address: sector taken from sector
      logic [7:0] sector;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_acc_t;

   // Flag update from the ALU
   typedef struct packed {
      logic       upd_c;
      logic       upd_ac;
      logic       upd_z;
      logic       upd_ov;
      logic       upd_cz;
      logic       c;
      logic       ac;
      logic       z;
      logic       ov;
      logic       cz;
      logic       msb;
   } sfr_flag_t;

   // Resolved data-memory address
   typedef struct packed {
      logic [7:0] sector;
      logic [7:0] addr;
   } sfr_loc_t;

   typedef enum logic [2:0] {
      SFR_RUN   = 3'b001,
      SFR_DUMMY = 3'b010,
      SFR_TBL   = 3'b100
   } sfr_state_t;
endpackage

//--- core/sfr_ram.sv
/*
 General-purpose data memory of all sectors, flip-flop storage.
 Assumes one access per cycle; out-of-range locations read zero.
*/
`timescale 1ns/100ps
module sfr_ram
   import sfr_pkg::*;
#(
   parameter int SECTORS = 2
) (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       we,
   input  wire sfr_loc_t   loc,
   input  wire logic [7:0] wdata,
   output logic [7:0]      rdata,
   output logic            hit
);
   localparam int DEPTH = SECTORS * 128;
   logic [7:0] mem_q [DEPTH];
   wire        in_sec  = loc.sector < 8'(SECTORS);
   wire        in_gp   = loc.addr >= SFR_GP_BASE;

   // Flat index: sector times 128 plus offset in the upper half
   wire [15:0] flat = 16'(loc.sector) * 16'd128 + 16'(loc.addr[6:0]);

   // Location exists only in an implemented sector's upper half
   assign hit   = in_sec && in_gp;
   assign rdata = hit ? mem_q[flat[$clog2(DEPTH)-1:0]] : READ_NONE;

   // Write port, ignored for missing locations
   always_ff @(posedge clock) begin
      if (we && hit) begin
         mem_q[flat[$clog2(DEPTH)-1:0]] <= wdata;
      end
   end
endmodule

//--- core/sfr_status.sv
/*
 Status register with protected power-down and time-out flags.
 Assumes halt, watchdog-clear and expiry events arrive as one-cycle pulses.
*/
`timescale 1ns/100ps
module sfr_status
   import sfr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   input  wire sfr_flag_t  flg,
   input  wire logic       halt_instr,
   input  wire logic       watchdog_clear_instr,
   input  wire logic       dog_expired,
   output logic [7:0]      status_q
);
   logic [7:0] status_d;

   // Next status: written bits, then ALU updates, then system flags
   always_comb begin
      status_d = status_q;
      if (wr) begin
         status_d = (status_q & ~ST_WR_MASK) | (wdata & ST_WR_MASK);
      end
      if (flg.upd_c)  status_d[ST_C]  = flg.c;
      if (flg.upd_ac) status_d[ST_AC] = flg.ac;
      if (flg.upd_z)  status_d[ST_Z]  = flg.z;
      if (flg.upd_ov) begin
         status_d[ST_OV] = flg.ov;
         status_d[ST_SC] = flg.ov ^ flg.msb;
      end
      if (flg.upd_cz) status_d[ST_CZ] = flg.cz;
      if (halt_instr) begin
         status_d[ST_PD] = 1'b1;
         status_d[ST_TO] = 1'b0;
      end
      if (watchdog_clear_instr) begin
         status_d[ST_PD] = 1'b0;
         status_d[ST_TO] = 1'b0;
      end
      if (dog_expired) status_d[ST_TO] = 1'b1;      // Expiry wins over a clear
   end

   // Power-up clears every bit including time-out and power-down
   always_ff @(posedge clock) begin
      if (sys_rst) status_q <= RST_BYTE;
      else         status_q <= status_d;
   end
endmodule

//--- test/sfr_core_sva.sv
/*
 Assertion checker for the special-function register core.
 Assumes it is bound to sfr_core and sees only that module's ports.
*/
`timescale 1ns/100ps
module sfr_core_sva
   import sfr_pkg::*;
#(
   parameter int PC_W    = 13,
   parameter int SECTORS = 2
) (
   input wire logic            clock,
   input wire logic            sys_rst,
   input wire sfr_acc_t        acc_req,
   input wire logic [7:0]      rdata_q,
   input wire logic            acc_load,
   input wire logic [7:0]      alu_result,
   input wire sfr_flag_t       alu_flags,
   input wire logic            pc_step,
   input wire logic            pc_load,
   input wire logic [PC_W-1:0] pc_target,
   input wire logic [PC_W-1:0] pc_q,
   input wire logic            table_read,
   input wire logic [7:0]      table_dest,
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic [15:0]     prog_word,
   input wire logic            halt_instr,
   input wire logic            watchdog_clear_instr,
   input wire logic            dog_expired,
   input wire logic            busy,
   input wire logic [7:0]      accumulator_q,
   input wire logic [7:0]      status_flags
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Decoded direct writes and event combinations
   wire             quiet  = !halt_instr && !watchdog_clear_instr && !dog_expired;
   wire             dir_wr = acc_req.wr && !acc_req.ext && !busy;
   wire             pcl_wr = dir_wr && acc_req.addr == SFR_PCLO && !pc_load && !pc_step;
   wire             st_hit = dir_wr && acc_req.addr == SFR_STAT;
   wire             st_wr  = st_hit && quiet && alu_flags[10:6] == 5'h00;
   wire [7:0]       wd     = acc_req.wdata;
   wire             c_in   = alu_flags.c;
   wire [PC_W-9:0]  pc_hi  = pc_q[PC_W-1:8];

   a_pcl_dummy_cycle: assert property (pcl_wr |=> busy ##1 !busy)
      else $error("busy not exactly one cycle after counter low write");
   a_pcl_page_jump: assert property (pcl_wr |=> pc_q == {$past(pc_hi), $past(wd)})
      else $error("counter low write did not jump within the page");
   a_status_wr_mask: assert property (st_wr |=> status_flags ==
      (($past(wd) & ST_WR_MASK) | ($past(status_flags) & ~ST_WR_MASK)))
      else $error("status write result wrong");
   a_pd_held: assert property (!halt_instr && !watchdog_clear_instr
      |=> $stable(status_flags[ST_PD])) else $error("power-down flag moved");
   a_to_held: assert property (quiet |=> $stable(status_flags[ST_TO]))
      else $error("time-out flag moved");
   a_halt_sets_pd: assert property (halt_instr && !watchdog_clear_instr && !dog_expired
      |=> status_flags[ST_PD] && !status_flags[ST_TO]) else $error("halt flags wrong");
   a_clear_both: assert property (watchdog_clear_instr && !dog_expired
      |=> !status_flags[ST_PD] && !status_flags[ST_TO]) else $error("clear flags wrong");
   a_acc_load: assert property (acc_load && !(dir_wr && acc_req.addr == SFR_ACC)
      |=> accumulator_q == $past(alu_result)) else $error("accumulator not loaded");
   a_carry_track: assert property (alu_flags.upd_c && !st_hit
      |=> status_flags[ST_C] == $past(c_in)) else $error("carry not tracked");
   a_table_busy: assert property (table_read && !busy |=> busy ##1 !busy)
      else $error("table read busy wrong");
   a_reset_clear: assert property (disable iff (1'b0) sys_rst
      |=> status_flags == 8'h00 && !busy) else $error("reset state wrong");

   // Main scenarios reached
   c_pcl: cover property (pcl_wr ##1 busy);
   c_table: cover property (table_read && !busy);
   c_halt: cover property (halt_instr ##1 status_flags[ST_PD]);
endmodule

bind sfr_core sfr_core_sva #(.PC_W(PC_W), .SECTORS(SECTORS)) u_sva (
   .clock(clock), .sys_rst(sys_rst), .acc_req(acc_req), .rdata_q(rdata_q),
   .acc_load(acc_load), .alu_result(alu_result), .alu_flags(alu_flags),
   .pc_step(pc_step), .pc_load(pc_load), .pc_target(pc_target), .pc_q(pc_q),
   .table_read(table_read), .table_dest(table_dest), .prog_addr(prog_addr),
   .prog_word(prog_word), .halt_instr(halt_instr), .busy(busy),
   .watchdog_clear_instr(watchdog_clear_instr), .dog_expired(dog_expired),
   .accumulator_q(accumulator_q), .status_flags(status_flags)
);

//--- test/sfr_core_tb.sv
/*
 Self-checking testbench for the special-function register core.
 Assumes sfr_core with two sectors; reads are checked from a queue.
*/
`timescale 1ns/100ps
module tb
   import sfr_pkg::*;
();
   localparam int PC_W = 13;
   logic            clock, sys_rst, acc_load, pc_step, pc_load, table_read, busy, pend;
   logic            halt_instr, watchdog_clear_instr, dog_expired;
   sfr_acc_t        acc_req;
   sfr_flag_t       alu_flags;
   logic [7:0]      alu_result, table_dest, rdata_q, accumulator_q, status_flags, w;
   logic [PC_W-1:0] pc_target, pc_q, prog_addr;
   logic [15:0]     prog_word;
   logic [31:0]     rnd;
   logic [7:0]      exp_q[$];
   logic [7:0]      vals[8];
   logic [7:0]      regs[8] = '{SFR_PTR0, SFR_PTR1L, SFR_PTR1S, SFR_PTR2L, SFR_PTR2S,
                                SFR_TBPL, SFR_TBPH, SFR_ACC};
   logic [7:0]      pdto[4] = '{8'h10, 8'h30, 8'h10, 8'h00};
   int              fail_count, num_checks;

   sfr_core #(.PC_W(PC_W), .SECTORS(2)) DUT (
      .clock(clock), .sys_rst(sys_rst), .acc_req(acc_req), .rdata_q(rdata_q),
      .acc_load(acc_load), .alu_result(alu_result), .alu_flags(alu_flags),
      .pc_step(pc_step), .pc_load(pc_load), .pc_target(pc_target), .pc_q(pc_q),
      .table_read(table_read), .table_dest(table_dest), .prog_addr(prog_addr),
      .prog_word(prog_word), .halt_instr(halt_instr), .busy(busy),
      .watchdog_clear_instr(watchdog_clear_instr), .dog_expired(dog_expired),
      .accumulator_q(accumulator_q), .status_flags(status_flags)
   );

   always #5 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      check(exp_q.size(), 0);
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One access for one edge; a read notes its expected byte
   task automatic op(input logic r, wr, e, input logic [7:0] s, a, d, x);
      acc_req <= '{rd: r, wr: wr, ext: e, sector: s, addr: a, wdata: d};
      if (r) exp_q.push_back(x);
      @(posedge clock);
   endtask

   task automatic idle();
      acc_req <= '0;
      @(posedge clock);
   endtask

   // Read data appears the cycle after a taken read
   always @(posedge clock) begin
      if (pend) check(rdata_q, exp_q.pop_front());
      pend <= acc_req.rd && !busy && !sys_rst;
   end

   // Hang guard
   initial begin
      repeat (3000) @(posedge clock);
      fail_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      {acc_load, pc_step, pc_load, table_read} = '0;
      {halt_instr, watchdog_clear_instr, dog_expired} = '0;
      acc_req = '0;
      alu_flags = '0;
      {alu_result, table_dest, pc_target, prog_word} = '0;
      {fail_count, num_checks} = '0;
      rnd = 32'h6B8E54C6;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      op(1,0,0,0,SFR_STAT,0,8'h00);
      op(1,0,0,0,8'h0B,0,8'h00);
      op(1,0,0,0,8'h3C,0,8'h00);
      foreach (regs[i]) begin
         rnd = lfsr(rnd);
         vals[i] = rnd[7:0];
         op(0,1,0,0,regs[i],rnd[7:0],0);
      end
      foreach (regs[i]) op(1,0,0,0,regs[i],0,vals[i]);
      // Port zero stays in sector 0; pointing at itself reads zero
      op(0,1,1,1,8'h85,8'hA5,0);
      op(0,1,0,0,SFR_PTR0,8'h85,0);
      op(0,1,0,0,SFR_IND0,8'h3C,0);
      op(1,0,1,0,8'h85,0,8'h3C);
      op(1,0,1,1,8'h85,0,8'hA5);
      op(0,1,0,0,SFR_PTR0,SFR_IND0,0);
      op(0,1,0,0,SFR_IND0,8'h77,0);
      op(1,0,0,0,SFR_IND0,0,8'h00);
      op(1,0,0,0,SFR_PTR0,0,SFR_IND0);
      // Port one reaches sector 1 place F0h, same as extended 1F0h
      op(0,1,0,0,8'hF0,8'h11,0);
      op(0,1,0,0,SFR_PTR1L,8'hF0,0);
      op(0,1,0,0,SFR_PTR1S,8'h01,0);
      op(0,1,0,0,SFR_IND1,8'h5E,0);
      op(1,0,1,1,8'hF0,0,8'h5E);
      op(1,0,0,0,8'hF0,0,8'h11);
      for (int s = 0; s < 2; s++) begin
         rnd = lfsr(rnd);
         w = {1'b1, rnd[6:0]};
         op(0,1,0,0,SFR_PTR2L,w,0);
         op(0,1,0,0,SFR_PTR2S,s[7:0],0);
         op(0,1,0,0,SFR_IND2,rnd[15:8],0);
         op(1,0,1,s[7:0],w,0,rnd[15:8]);
      end
      // Missing sector and unused special place through a port
      op(0,1,0,0,SFR_PTR1S,8'h05,0);
      op(0,1,0,0,SFR_IND1,8'h99,0);
      op(1,0,0,0,SFR_IND1,0,8'h00);
      op(0,1,0,0,SFR_PTR1S,8'h00,0);
      op(0,1,0,0,SFR_PTR1L,8'h3C,0);
      op(1,0,0,0,SFR_IND1,0,8'h00);
      op(0,1,0,0,SFR_STAT,8'hFF,0);
      op(1,0,0,0,SFR_STAT,0,8'hFF & ST_WR_MASK);
      idle();
      // Accumulator and flags follow each ALU result
      repeat (4) begin
         rnd = lfsr(rnd);
         acc_load <= 1'b1;
         alu_result <= rnd[7:0];
         alu_flags <= {5'h1F, rnd[13:8]};
         @(posedge clock);
         acc_load <= 1'b0;
         alu_flags <= '0;
         w = {rnd[10] ^ rnd[8], rnd[9], 2'b00, rnd[10], rnd[11], rnd[12], rnd[13]};
         op(1,0,0,0,SFR_ACC,0,rnd[7:0]);
         op(1,0,0,0,SFR_STAT,0,w);
         check(accumulator_q, rnd[7:0]);
         check(status_flags, w);
         idle();
      end
      // Halt, expiry, halt, clear; a status write must spare both flags
      for (int k = 0; k < 4; k++) begin
         halt_instr <= (k == 0 || k == 2);
         dog_expired <= (k == 1);
         watchdog_clear_instr <= (k == 3);
         @(posedge clock);
         {halt_instr, dog_expired, watchdog_clear_instr} <= 3'h0;
         op(0,1,0,0,SFR_STAT,8'h00,0);
         op(1,0,0,0,SFR_STAT,0,pdto[k]);
         idle();
      end
      // Counter low write jumps in page and costs one dummy cycle
      pc_load <= 1'b1;
      pc_target <= 13'h1ABC;
      @(posedge clock);
      pc_load <= 1'b0;
      pc_step <= 1'b1;
      @(posedge clock);
      pc_step <= 1'b0;
      op(0,1,0,0,SFR_PCLO,8'h5A,0);
      acc_req <= '0;
      #1;
      check(busy, 1'b1);
      check(pc_q, 13'h1A5A);
      @(posedge clock);
      #1;
      check(busy, 1'b0);
      @(posedge clock);
      // Table read: high byte latched, low byte to destination
      rnd = lfsr(rnd);
      op(0,1,0,0,SFR_TBPL,rnd[7:0],0);
      op(0,1,0,0,SFR_TBPH,8'h03,0);
      acc_req <= '0;
      table_read <= 1'b1;
      table_dest <= 8'h88;
      prog_word <= rnd[31:16];
      #1;
      check(prog_addr, {5'h03, rnd[7:0]});
      @(posedge clock);
      table_read <= 1'b0;
      @(posedge clock);
      op(1,0,0,0,SFR_TBDH,0,rnd[31:24]);
      op(0,1,0,0,SFR_TBDH,8'h00,0);
      op(1,0,0,0,SFR_TBDH,0,rnd[31:24]);
      op(1,0,0,0,8'h88,0,rnd[23:16]);
      op(0,1,0,0,SFR_TBPL,rnd[7:0] + 8'h01,0);
      idle();
      #1;
      check(prog_addr, {5'h03, rnd[7:0] + 8'h01});
      repeat (3) @(posedge clock);
      wrap_up();
   end
endmodule
